// ===== verif/dcfd_checker_assertions.sv
// Port assertions for the two-channel fault diagnosis block
`timescale 1ns/100ps
`default_nettype none
module dcfd_checker #(
   parameter FAULT_CYC = 8
) (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       reset_n,
   // Pins and configuration
   input wire logic [1:0] ctrl_in,
   input wire logic [1:0] cond_short_gnd,
   input wire logic [1:0] cond_overtemp,
   input wire logic       cs_n,
   input wire logic       sense_en,
   input wire logic [1:0] sense_sel,
   // Outputs under watch
   input wire logic [1:0] gate_on_reg,
   input wire logic [1:0] channel_status_pin_reg,
   input wire logic       fault_n_reg,
   input wire logic [3:0] diag_code_reg,
   input wire logic [1:0] overtemp_flag_reg,
   input wire logic [1:0] protect_diag_flag_reg,
   input wire logic [1:0] short_gnd_flag_reg,
   input wire logic       sense_sink_en_reg,
   input wire logic [1:0] sense_route_reg
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   logic       cs_q;
   logic       ctl_q;
   logic [3:0] cs_age;
   logic [7:0] inv_cnt;
   logic [7:0] sg_run;
   // Age since select rose, run of short with steady input; saturate so they never wrap
   always @(posedge clk_sys) begin
      cs_q <= cs_n;
      ctl_q <= ctrl_in[0];
      if (!reset_n) begin
         cs_age <= 4'hf;
         inv_cnt <= 8'h0;
         sg_run <= 8'h0;
      end else begin
         sg_run <= cond_short_gnd[0] ? sg_run + {7'h0, sg_run != 8'hff} : 8'h0;
         cs_age <= (cs_n && !cs_q) ? 4'h0 : cs_age + {3'h0, cs_age != 4'hf};
         inv_cnt <= (cond_short_gnd[0] && ctrl_in[0] == ctl_q) ? inv_cnt + {7'h0, inv_cnt != 8'hff} : 8'h0;
      end
   end
   // Steady input with a clean code long enough to cover the latch lag
   sequence s_quiet;
      $stable(ctrl_in[0]) [*4] ##1 ($stable(ctrl_in[0]) && diag_code_reg[1:0] == 2'h3) [*3];
   endsequence
   sequence s_ot_hit;
      $rose(cond_overtemp[0]) ##1 cond_overtemp[0] [*3];
   endsequence
   sequence s_sense_held;
      (sense_en && sense_sel != 2'h3 && $stable(sense_sel)) [*5];
   endsequence
   AST_FOLLOW: assert property (s_quiet |-> $past(channel_status_pin_reg[0], 3) == ctrl_in[0])
      else $error("status pin not following input");
   AST_INVERT: assert property (inv_cnt >= 8'(FAULT_CYC + 8) |-> channel_status_pin_reg[0] == !ctrl_in[0])
      else $error("status pin not inverted under fault");
   AST_FILTER: assert property ($rose(short_gnd_flag_reg[0]) |-> sg_run >= 8'(FAULT_CYC) && $past(cond_short_gnd[0], 4))
      else $error("short flag set without a held fault");
   AST_OT_FAST: assert property (s_ot_hit |-> overtemp_flag_reg[0] && !gate_on_reg[0])
      else $error("overtemp not acted on at once");
   AST_MERGE: assert property ($rose(overtemp_flag_reg[1]) |-> ##[0:1] protect_diag_flag_reg[1])
      else $error("protect flag missing overtemp");
   AST_FAULT: assert property ((|short_gnd_flag_reg || |protect_diag_flag_reg) |-> ##[0:1] !fault_n_reg)
      else $error("fault output high with a latched flag");
   AST_CODE: assert property (protect_diag_flag_reg[1] |-> ##[0:1] diag_code_reg[3:2] == 2'h2)
      else $error("protect code missing");
   AST_CLEAR: assert property ($fell(short_gnd_flag_reg[0]) |-> cs_age < 4'h8)
      else $error("latched flag dropped without a transfer");
   AST_SENSE: assert property (s_sense_held |-> sense_sink_en_reg && sense_route_reg == sense_sel)
      else $error("sense routing wrong");
endmodule // dcfd_checker
`default_nettype wire

// ===== verif/dcfd_diag_tb.sv
// Self-checking bench for the two-channel fault diagnosis block
`timescale 1ns/100ps
`default_nettype none
module dcfd_diag_tb;
   // Stimulus, outputs and expectation queues
   logic       clk_sys = 1'b0;
   logic       reset_n = 1'b0;
   logic [1:0] ctrl_in = 2'h0, cond_short_gnd = 2'h0, cond_open_load = 2'h0, cond_under_cur = 2'h0;
   logic [1:0] cond_overload = 2'h0, cond_overtemp = 2'h0, sense_sel = 2'h0;
   logic       ovl_latch_mode = 1'b0, ot_latch_mode = 1'b0, slew_rate2 = 1'b0, sense_en = 1'b0;
   wire        cs_n, sclk, fault_n_reg, sense_sink_en_reg;
   wire  [1:0] gate_on_reg, channel_status_pin_reg, overtemp_flag_reg, protect_diag_flag_reg;
   wire  [1:0] open_load_flag_reg, under_current_flag_reg, short_gnd_flag_reg, overload_flag_reg, sense_route_reg;
   wire  [3:0] diag_code_reg;
   logic [2:0] kq[$];
   logic [3:0] vq[$];
   int         fails = 0, checks_done = 0, cyc = 0;
   integer     seed = 32'hffbf8df2;
   always #12.5 clk_sys = ~clk_sys;
   dcfd_diag #(.FAULT_CYC(8), .OFF1_CYC(8), .OFF2_CYC(16)) i_dcfd_diag (
      .clk_sys, .reset_n, .ctrl_in, .cond_short_gnd, .cond_open_load, .cond_under_cur, .cond_overload,
      .cond_overtemp, .cs_n, .sclk, .ovl_latch_mode, .ot_latch_mode, .slew_rate2, .sense_en, .sense_sel,
      .gate_on_reg, .channel_status_pin_reg, .fault_n_reg, .diag_code_reg, .overtemp_flag_reg,
      .protect_diag_flag_reg, .open_load_flag_reg, .under_current_flag_reg, .short_gnd_flag_reg,
      .overload_flag_reg, .sense_sink_en_reg, .sense_route_reg);
   dcfd_host i_dcfd_host (.clk_sys, .cs_n, .sclk);
   task automatic cy(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic note(input logic [2:0] k, input logic [3:0] v);
      kq.push_back(k);
      vq.push_back(v);
   endtask
   // One compare for every 4-bit view of the outputs
   task automatic cmp(input logic [2:0] k, input logic [3:0] e);
      logic [3:0] s;
      string      nm[8] = '{"status", "code", "fault_n", "sg_ol", "ot_prot", "gate", "sense", "ovl_uc"};
      s = (k == 0) ? {2'h0, channel_status_pin_reg} : (k == 1) ? diag_code_reg : (k == 2) ? {3'h0, fault_n_reg} :
          (k == 3) ? {short_gnd_flag_reg, open_load_flag_reg} : (k == 4) ? {overtemp_flag_reg, protect_diag_flag_reg} :
          (k == 5) ? {2'h0, gate_on_reg} : (k == 6) ? {1'b0, sense_sink_en_reg, sense_route_reg} :
          {overload_flag_reg, under_current_flag_reg};
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm[k], e, s);
      end
   endtask
   // Runs just after the falling edge, so a note made at that edge is compared in the same cycle
   always @(negedge clk_sys) begin
      #1;
      while (vq.size() > 0) begin
         cmp(kq.pop_front(), vq.pop_front());
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Hang guard, far above the few thousand cycles the tests need
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 8000) begin
         fails++;
         tally_and_finish();
      end
   end
   // Main sequence
   initial begin
      cy(6);
      reset_n = 1'b1;
      repeat (8) begin
         ctrl_in = 2'($random(seed));
         cy(5);
         note(0, {2'h0, ctrl_in});
      end
      $display("follow test done");
      ctrl_in = 2'h1;
      for (int j = 0; j < 3; j++) begin
         {cond_under_cur[0], cond_open_load[0], cond_short_gnd[0]} = 3'h1 << j;
         cy(4);
         {cond_under_cur[0], cond_open_load[0], cond_short_gnd[0]} = 3'h0;
         cy(20);
         note(2, 4'h1);
         note(0, 4'h1);
      end
      $display("glitch test done");
      ctrl_in = 2'h2;
      cond_short_gnd[0] = 1'b1;
      cond_under_cur[1] = 1'b1;
      cy(25);
      note(0, 4'h1);
      note(1, 4'h4);
      note(2, 4'h0);
      note(3, 4'h4);
      note(7, 4'h2);
      cond_short_gnd[0] = 1'b0;
      cond_under_cur[1] = 1'b0;
      cy(8);
      note(0, 4'h2);
      note(3, 4'h4);
      note(7, 4'h2);
      i_dcfd_host.xfer(7, 8);
      note(3, 4'h4);
      note(7, 4'h2);
      i_dcfd_host.xfer(16, 12);
      note(3, 4'h0);
      note(7, 4'h0);
      note(2, 4'h1);
      ctrl_in = 2'h0;
      cond_open_load[1] = 1'b1;
      cy(20);
      note(0, 4'h2);
      note(1, 4'h7);
      note(3, 4'h2);
      cond_open_load[1] = 1'b0;
      i_dcfd_host.xfer(8, 8);
      note(3, 4'h0);
      $display("latch test done");
      ctrl_in = 2'h3;
      cy(5);
      cond_overtemp[1] = 1'b1;
      cy(6);
      note(5, 4'h1);
      note(4, 4'ha);
      note(1, 4'hb);
      cond_overtemp[1] = 1'b0;
      cy(6);
      note(5, 4'h3);
      i_dcfd_host.xfer(8, 8);
      note(4, 4'h0);
      cond_overload[1] = 1'b1;
      cy(20);
      note(5, 4'h3);
      note(0, 4'h1);
      note(7, 4'h8);
      note(2, 4'h0);
      cond_overload[1] = 1'b0;
      i_dcfd_host.xfer(8, 8);
      note(7, 4'h0);
      ot_latch_mode = 1'b1;
      ovl_latch_mode = 1'b1;
      slew_rate2 = 1'b1;
      ctrl_in = 2'h1;
      cond_overtemp[0] = 1'b1;
      cy(5);
      cond_overtemp[0] = 1'b0;
      cy(8);
      note(5, 4'h0);
      ctrl_in = 2'h0;
      cy(4);
      ctrl_in = 2'h1;
      cy(6);
      note(5, 4'h1);
      cond_overload[0] = 1'b1;
      cy(30);
      cond_overload[0] = 1'b0;
      cy(4);
      note(5, 4'h0);
      i_dcfd_host.xfer(8, 8);
      note(7, 4'h4);
      note(4, 4'h5);
      ctrl_in = 2'h0;
      cy(4);
      i_dcfd_host.xfer(8, 8);
      note(7, 4'h0);
      note(4, 4'h0);
      $display("protection test done");
      sense_en = 1'b1;
      for (int j = 0; j < 4; j++) begin
         sense_sel = 2'(j);
         cy(160); // Sense settle time of 4 us before sampling
         note(6, {1'b0, j != 3, 2'(j)});
      end
      $display("sense test done");
      cy(2);
      tally_and_finish();
   end
endmodule // dcfd_diag_tb
bind dcfd_diag dcfd_checker #(.FAULT_CYC(FAULT_CYC)) i_dcfd_checker (.clk_sys, .reset_n, .ctrl_in,
   .cond_short_gnd, .cond_overtemp, .cs_n, .sense_en, .sense_sel, .gate_on_reg, .channel_status_pin_reg,
   .fault_n_reg, .diag_code_reg, .overtemp_flag_reg, .protect_diag_flag_reg, .short_gnd_flag_reg,
   .sense_sink_en_reg, .sense_route_reg);
`default_nettype wire

// ===== verif/dcfd_host.sv
// Host model framing serial transfers with chip select and serial clock
`timescale 1ns/100ps
`default_nettype none
module dcfd_host (
   // Clock
   input  wire logic clk_sys,
   // Serial framing pins
   output var logic  cs_n,
   output var logic  sclk
);
   // Idle levels match the pin pulls: select high, clock low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
   end
   // n clocks of hp cycles per half; clock stays low at select edges
   task automatic xfer(input int n, input int hp);
      repeat (hp) @(negedge clk_sys);
      cs_n = 1'b0;
      repeat (n) begin
         repeat (hp) @(negedge clk_sys);
         sclk = 1'b1;
         repeat (hp) @(negedge clk_sys);
         sclk = 1'b0;
      end
      repeat (hp) @(negedge clk_sys);
      cs_n = 1'b1;
      repeat (4 * hp) @(negedge clk_sys);
   endtask
endmodule // dcfd_host
`default_nettype wire

// ===== verilog/dcfd_consts.vh
// Constants for the dual channel fault diagnosis block
`ifndef DCFD_CONSTS_VH
`define DCFD_CONSTS_VH
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define DCFD_CLK_PERIOD_NS   25
`define DCFD_T_FAULT_MIN_NS  50000
`define DCFD_T_OFF1_MAX_NS   50000
`define DCFD_T_OFF2_MAX_NS   150000
// Least time rounds up, longest time rounds down
`define DCFD_FAULT_CYC ((`DCFD_T_FAULT_MIN_NS + `DCFD_CLK_PERIOD_NS - 1) / `DCFD_CLK_PERIOD_NS)
`define DCFD_OFF1_CYC  (`DCFD_T_OFF1_MAX_NS / `DCFD_CLK_PERIOD_NS)
`define DCFD_OFF2_CYC  (`DCFD_T_OFF2_MAX_NS / `DCFD_CLK_PERIOD_NS)
// ---------------------------------------------------------------
// Diagnosis codes, MSB then LSB
// ---------------------------------------------------------------
`define DCFD_CODE_NORMAL  2'h3
`define DCFD_CODE_SG_LOW  2'h0
`define DCFD_CODE_LOAD    2'h1
`define DCFD_CODE_PROTECT 2'h2
// ---------------------------------------------------------------
// Sense selection
// ---------------------------------------------------------------
`define DCFD_SENSE_CH1 2'h0
`define DCFD_SENSE_CH2 2'h1
`define DCFD_SENSE_SUM 2'h2
`define DCFD_SENSE_OFF 2'h3
`endif

// ===== verilog/dcfd_diag.v
// Two-channel fault diagnosis, status pins, latched flags and sense select
// Notes on behaviour
// - Per channel, overload and overtemperature flags merge into one protect flag.
// - Per channel, open load, under current and short to ground flags kept separate.
// - Faults except overtemperature count only after persisting past the filter time.
// - With no recognised fault, the status pin follows the control input.
// - With a recognised fault, status shows inverted input; no latching except the overload shutdown latch in latch mode.
// - Recognised faults are latched for serial and fault pin reporting.
// - Latched flags clear on chip select rising after a successful transfer.
// - Two-bit code per channel; fault output low on any latched fault.
// - Current limit mode keeps output on, reports overload after filter time.
// - Latch mode turns output off after slew-dependent delay; short overloads ignored.
// - Overtemp auto-restart: output off, flag set immediately, restart on cooling.
// - Overtemp latch mode: output off until a falling control input edge.
// - Sense sink enabled when selected, tracking the chosen channel.
// - Sense may track the sum of both channels.
// - Latch mode overload flag clears only if input is low at chip select rise.
`timescale 1ns/100ps
`default_nettype none
`include "dcfd_consts.vh"
module dcfd_diag #(
   parameter CNT_W     = 13,
   parameter FAULT_CYC = `DCFD_FAULT_CYC,
   parameter OFF1_CYC  = `DCFD_OFF1_CYC,
   parameter OFF2_CYC  = `DCFD_OFF2_CYC
) (
   // Clock and reset
   input  wire       clk_sys,
   input  wire       reset_n,
   // Channel control inputs (pins)
   input  wire [1:0] ctrl_in,
   // Raw fault comparators per channel (asynchronous)
   input  wire [1:0] cond_short_gnd,
   input  wire [1:0] cond_open_load,
   input  wire [1:0] cond_under_cur,
   input  wire [1:0] cond_overload,
   input  wire [1:0] cond_overtemp,
   // Serial port framing pins
   input  wire       cs_n,
   input  wire       sclk,
   // Configuration
   input  wire       ovl_latch_mode,
   input  wire       ot_latch_mode,
   input  wire       slew_rate2,
   input  wire       sense_en,
   input  wire [1:0] sense_sel,
   // Power stage and pins
   output reg  [1:0] gate_on_reg,
   output reg  [1:0] channel_status_pin_reg,
   output reg        fault_n_reg,
   // Latched diagnosis
   output reg  [3:0] diag_code_reg,
   output reg  [1:0] overtemp_flag_reg,
   output reg  [1:0] protect_diag_flag_reg,
   output reg  [1:0] open_load_flag_reg,
   output reg  [1:0] under_current_flag_reg,
   output reg  [1:0] short_gnd_flag_reg,
   output reg  [1:0] overload_flag_reg,
   // Current sense
   output reg        sense_sink_en_reg,
   output reg  [1:0] sense_route_reg
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   // Unfiltered control, fault and select effects lag their pin by three edges: two sync flops and the output flop
   // Select, clock and every comparator but overtemperature share one stage, so their relative order is kept
   reg [11:0] meta_reg;
   reg [11:0] sync_reg;
   reg [1:0]  in_d_reg;
   reg        cs_d_reg;
   reg        sclk_d_reg;
   // Named slices of the synchronised pin word
   wire [1:0] in_s  = sync_reg[1:0];
   wire [1:0] sg_s  = sync_reg[3:2];
   wire [1:0] ol_s  = sync_reg[5:4];
   wire [1:0] uc_s  = sync_reg[7:6];
   wire [1:0] ovl_s = sync_reg[9:8];
   wire       cs_s  = sync_reg[11];
   reg  [1:0] ot_sync_reg;
   reg  [1:0] ot_meta_reg;

   // Two flops on every fault, control and framing pin before logic reads it; sense and configuration pins are read directly
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         meta_reg    <= 12'h800;
         sync_reg    <= 12'h800;
         ot_meta_reg <= 2'h0;
         ot_sync_reg <= 2'h0;
         in_d_reg    <= 2'h0;
         cs_d_reg    <= 1'b1;
         sclk_d_reg  <= 1'b0;
      end else begin
         meta_reg    <= {cs_n, sclk, cond_overload, cond_under_cur, cond_open_load, cond_short_gnd, ctrl_in};
         sync_reg    <= meta_reg;
         ot_meta_reg <= cond_overtemp;
         ot_sync_reg <= ot_meta_reg;
         in_d_reg    <= in_s;
         cs_d_reg    <= cs_s;
         sclk_d_reg  <= sync_reg[10];
      end
   end

   // ---------------------------------------------------------------
   // Serial transfer framing
   // ---------------------------------------------------------------
   // Edges are found on synchronised copies; serial clock high and low times
   // must each span at least two system clocks or a clock edge is lost
   reg  [2:0] bit_cnt_reg;
   reg        any_clk_reg;
   wire       cs_fall = cs_d_reg & ~cs_s;
   wire       cs_rise = ~cs_d_reg & cs_s;
   wire       sclk_rise = ~sclk_d_reg & sync_reg[10];
   // Whole multiple of eight clocks, at least one byte
   wire       xfer_ok = cs_rise & any_clk_reg & (bit_cnt_reg == 3'h0);

   // Count serial clocks modulo eight inside a frame
   always @(posedge clk_sys) begin
      if (!reset_n || cs_fall) begin
         bit_cnt_reg <= 3'h0;
         any_clk_reg <= 1'b0;
      end else if (!cs_s && sclk_rise) begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         any_clk_reg <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Filters
   // ---------------------------------------------------------------
   // One counter per filtered condition and channel, two for overload; a drop of the condition restarts it
   // The switch-off limit follows the slew setting live, so change it only while idle
   wire [CNT_W-1:0] fault_lim = FAULT_CYC[CNT_W-1:0];
   wire [CNT_W-1:0] off_lim   = slew_rate2 ? OFF2_CYC[CNT_W-1:0] : OFF1_CYC[CNT_W-1:0];
   wire [1:0] sg_live;
   wire [1:0] ol_live;
   wire [1:0] uc_live;
   wire [1:0] ovl_filt;
   wire [1:0] ovl_trip;

   genvar n;
   generate
      for (n = 0; n < 2; n = n + 1) begin : g_ch
         // Short to ground, filtered
         dcfd_filter #(
            .CNT_W    (CNT_W)
         ) u_sg (
            .clk_sys  (clk_sys),
            .reset_n  (reset_n),
            .cond     (sg_s[n]),
            .limit    (fault_lim),
            .flag_reg (sg_live[n])
         );
         // Open load only judged with the channel off
         dcfd_filter #(
            .CNT_W    (CNT_W)
         ) u_ol (
            .clk_sys  (clk_sys),
            .reset_n  (reset_n),
            .cond     (ol_s[n] & ~in_s[n]),
            .limit    (fault_lim),
            .flag_reg (ol_live[n])
         );
         // Under current only judged with the channel on
         dcfd_filter #(
            .CNT_W    (CNT_W)
         ) u_uc (
            .clk_sys  (clk_sys),
            .reset_n  (reset_n),
            .cond     (uc_s[n] & in_s[n]),
            .limit    (fault_lim),
            .flag_reg (uc_live[n])
         );
         // Overload in current-limit mode
         dcfd_filter #(
            .CNT_W    (CNT_W)
         ) u_ovl (
            .clk_sys  (clk_sys),
            .reset_n  (reset_n),
            .cond     (ovl_s[n] & in_s[n]),
            .limit    (fault_lim),
            .flag_reg (ovl_filt[n])
         );
         // Overload switch-off delay in latching mode
         dcfd_filter #(
            .CNT_W    (CNT_W)
         ) u_off (
            .clk_sys  (clk_sys),
            .reset_n  (reset_n),
            .cond     (ovl_s[n] & in_s[n] & ovl_latch_mode),
            .limit    (off_lim),
            .flag_reg (ovl_trip[n])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Shutdown latches
   // ---------------------------------------------------------------
   reg  [1:0] ovl_off_reg;
   reg  [1:0] ot_off_reg;
   // Falling edge of the synchronised control input releases both latches
   wire [1:0] in_fall = in_d_reg & ~in_s;

   // Latches release only when the channel is switched off by its input or when their latch mode is cleared
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         ovl_off_reg <= 2'h0;
         ot_off_reg  <= 2'h0;
      end else begin
         ovl_off_reg <= ovl_trip | (ovl_off_reg & ~in_fall & {2{ovl_latch_mode}});
         ot_off_reg  <= (ot_sync_reg | (ot_off_reg & ~in_fall)) & {2{ot_latch_mode}};
      end
   end

   // ---------------------------------------------------------------
   // Live fault view
   // ---------------------------------------------------------------
   // In latching mode the overload view is the shutdown latch, not the live filter
   wire [1:0] ovl_live   = ovl_latch_mode ? ovl_off_reg : ovl_filt;
   // Overtemperature bypasses filtering
   wire [1:0] fault_live = sg_live | ol_live | uc_live | ovl_live | ot_sync_reg;
   wire [1:0] gate_next  = in_s & ~ovl_off_reg & ~ot_sync_reg & ~ot_off_reg;

   // ---------------------------------------------------------------
   // Latched diagnosis flags
   // ---------------------------------------------------------------
   // A clear and a new event in one cycle keep the flag: the event wins
   wire [1:0] clr_all = {2{xfer_ok}};
   // Latched-mode flags survive a clear while the input is still high
   wire [1:0] clr_ovl = clr_all & (~in_s | {2{~ovl_latch_mode}});
   wire [1:0] clr_ot  = clr_all & (~in_s | {2{~ot_latch_mode}});
   wire [1:0] sg_l_next  = sg_live  | (short_gnd_flag_reg     & ~clr_all);
   wire [1:0] ol_l_next  = ol_live  | (open_load_flag_reg     & ~clr_all);
   wire [1:0] uc_l_next  = uc_live  | (under_current_flag_reg & ~clr_all);
   wire [1:0] ovl_l_next = ovl_live | (overload_flag_reg      & ~clr_ovl);
   wire [1:0] ot_l_next  = ot_sync_reg | (overtemp_flag_reg   & ~clr_ot);
   wire [1:0] prot_next  = ovl_l_next | ot_l_next;

   // Diagnosis code per channel, protective faults first
   function [1:0] code_of;
      input prot;
      input sg;
      input load;
      input in_lvl;
      begin
         if (prot)
            code_of = `DCFD_CODE_PROTECT;
         else if (sg && !in_lvl)
            code_of = `DCFD_CODE_SG_LOW;
         else if (sg || load)
            code_of = `DCFD_CODE_LOAD;
         else
            code_of = `DCFD_CODE_NORMAL;
      end
   endfunction

   // Register flags, codes and pin drives; set always beats clear
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         gate_on_reg            <= 2'h0;
         channel_status_pin_reg <= 2'h0;
         fault_n_reg            <= 1'b1;
         diag_code_reg          <= {`DCFD_CODE_NORMAL, `DCFD_CODE_NORMAL};
         overtemp_flag_reg      <= 2'h0;
         protect_diag_flag_reg  <= 2'h0;
         open_load_flag_reg     <= 2'h0;
         under_current_flag_reg <= 2'h0;
         short_gnd_flag_reg     <= 2'h0;
         overload_flag_reg      <= 2'h0;
      end else begin
         gate_on_reg            <= gate_next;
         channel_status_pin_reg <= in_s ^ fault_live;
         short_gnd_flag_reg     <= sg_l_next;
         open_load_flag_reg     <= ol_l_next;
         under_current_flag_reg <= uc_l_next;
         overload_flag_reg      <= ovl_l_next;
         overtemp_flag_reg      <= ot_l_next;
         protect_diag_flag_reg  <= prot_next;
         fault_n_reg            <= ~|(sg_l_next | ol_l_next | uc_l_next | prot_next);
         diag_code_reg[1:0]     <= code_of(prot_next[0], sg_l_next[0], ol_l_next[0] | uc_l_next[0], in_s[0]);
         diag_code_reg[3:2]     <= code_of(prot_next[1], sg_l_next[1], ol_l_next[1] | uc_l_next[1], in_s[1]);
      end
   end

   // ---------------------------------------------------------------
   // Current sense selection
   // ---------------------------------------------------------------
   // Selection 3 parks the sink; any other value routes one channel or the sum
   // The analog sink follows these controls; host waits settle time after a change
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         sense_sink_en_reg <= 1'b0;
         sense_route_reg   <= `DCFD_SENSE_OFF;
      end else begin
         sense_sink_en_reg <= sense_en && (sense_sel != `DCFD_SENSE_OFF);
         sense_route_reg   <= sense_en ? sense_sel : `DCFD_SENSE_OFF;
      end
   end
endmodule // dcfd_diag
`default_nettype wire

// ===== verilog/dcfd_filter.v
// Persistence filter: flags a condition that has held for a set count
`timescale 1ns/100ps
`default_nettype none
module dcfd_filter #(
   parameter CNT_W = 13
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             reset_n,
   // Condition and limit
   input  wire             cond,
   input  wire [CNT_W-1:0] limit,
   // Qualified flag
   output reg              flag_reg
);
   reg [CNT_W-1:0] cnt_reg;

   // Count while the condition holds; any drop restarts, so glitches never qualify
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         cnt_reg  <= {CNT_W{1'b0}};
         flag_reg <= 1'b0;
      end else if (!cond) begin
         cnt_reg  <= {CNT_W{1'b0}};
         flag_reg <= 1'b0;
      end else begin
         if (cnt_reg != limit)
            cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
         flag_reg <= (cnt_reg == limit);
      end
   end
endmodule // dcfd_filter
`default_nettype wire
